// ### dsq_defs.vh
// task-file offsets, status and error fields, opcodes and timing for the command block
`ifndef DSQ_DEFS_VH
`define DSQ_DEFS_VH
`define DSQ_A_DATA    4'h0
`define DSQ_A_FEAT    4'h1
`define DSQ_A_SCNT    4'h2
`define DSQ_A_SNUM    4'h3
`define DSQ_A_CYLL    4'h4
`define DSQ_A_CYLH    4'h5
`define DSQ_A_DEVH    4'h6
`define DSQ_A_CMD     4'h7
`define DSQ_A_PDCFG   4'h8
`define DSQ_A_PWR     4'h9
`define DSQ_OP_STBI0  8'hE0
`define DSQ_OP_STBI1  8'h94
`define DSQ_OP_WBUF   8'hE8
`define DSQ_OP_RBUF   8'hE4
`define DSQ_OP_WDQ0   8'hCA
`define DSQ_OP_WDQ1   8'hCB
`define DSQ_OP_SVC    8'hA2
`define DSQ_ST_BSY    7
`define DSQ_ST_RDY    6
`define DSQ_ST_DF     5
`define DSQ_ST_SRV    4
`define DSQ_ST_DRQ    3
`define DSQ_ST_COR    2
`define DSQ_ST_ERR    0
`define DSQ_ER_IDN    4
`define DSQ_ER_ABT    2
`define DSQ_SC_REL    3'b100
`define DSQ_SC_DONE   3'b011
`define DSQ_WORDS_LAST 8'hFF
`define DSQ_NSEC_ZERO 9'h1_00
`define DSQ_PD_UNIT_S 5
`define DSQ_CLK_HZ    100000000
`define DSQ_PD_TICK_CYC (`DSQ_PD_UNIT_S * `DSQ_CLK_HZ)
`endif

// ### dsq_buf_mem.v
// one-sector 256 x 16 buffer with registered read data
`timescale 1ns/1ns
module dsq_buf_mem (
  input  wire        mclk,
  input  wire        we,
  input  wire [7:0]  waddr,
  input  wire [15:0] wdata,
  input  wire [7:0]  raddr,
  output reg  [15:0] rdata_q
);
  reg [15:0] mem [0:255];

  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

// ### dsq_pd_timer.v
// automatic power-down timer, counted in 5 s units, restarted by any host access
`timescale 1ns/1ns
`include "dsq_defs.vh"
module dsq_pd_timer #(
  parameter TICK_CYC = `DSQ_PD_TICK_CYC
) (
  input  wire       mclk,
  input  wire       rst,
  input  wire [7:0] timeout,
  input  wire       restart,
  output reg        expire_q
);
  reg [31:0] pre_q;
  reg [7:0]  units_q;

  always @(posedge mclk) begin
    if (rst || restart || timeout == 8'h00) begin
      pre_q    <= 32'h0000_0000;
      units_q  <= 8'h00;
      expire_q <= 1'b0;
    end else if (!expire_q) begin
      if (pre_q == TICK_CYC - 1) begin
        pre_q <= 32'h0000_0000;
        if (units_q == timeout - 8'h01) begin
          expire_q <= 1'b1;
        end else begin
          units_q <= units_q + 8'h01;
        end
      end else begin
        pre_q <= pre_q + 32'h0000_0001;
      end
    end
  end
endmodule

// ### dsq_cmd.v
// command execution for standby immediate, write buffer and queued dma write
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
`include "dsq_defs.vh"
module dsq_cmd #(
  parameter PD_TICK_CYC = `DSQ_PD_TICK_CYC
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata_q,
  output reg         intrq_q,
  output reg         dmarq_q,
  input  wire        dma_strobe,
  input  wire [15:0] dma_data,
  output reg         media_wvalid_q,
  output reg  [15:0] media_wdata_q,
  input  wire        media_ready,
  input  wire        media_err,
  output reg         spin_en_q,
  input  wire        spin_at_speed
);
  localparam S_IDLE = 3'd0;
  localparam S_WBUF = 3'd1;
  localparam S_RBUF = 3'd2;
  localparam S_QREL = 3'd3;
  localparam S_QXFR = 3'd4;
  localparam S_QEND = 3'd5;

  reg [2:0]  st_q;
  reg [7:0]  feat_q;
  reg [7:0]  scnt_q;
  reg [7:0]  snum_q;
  reg [7:0]  cyll_q;
  reg [7:0]  cylh_q;
  reg [7:0]  devh_q;
  reg [7:0]  err_q;
  reg        bsy_q;
  reg        drq_q;
  reg        errb_q;
  reg        srv_q;
  reg        qact_q;
  reg        qerr_q;
  reg [4:0]  tag_q;
  reg [8:0]  nsec_q;
  reg [8:0]  sdone_q;
  reg [27:0] lba_q;
  reg [7:0]  wcnt_q;
  reg [7:0]  ptr_q;
  reg [7:0]  pdcfg_q;

  wire       cmd_wr;
  wire       data_wr;
  wire       data_rd;
  wire       stat_rd;
  wire [7:0] op;
  wire [7:0] raddr;
  wire [15:0] mem_rdata;
  wire       pd_expire;
  wire [27:0] fail_lba;
  wire       mem_we;
  wire       host_acc;
  wire       ptr_last;
  wire       sect_last;
  wire       svc_ok;
  wire [7:0] status;

  function hit;
    input [3:0] a;
    input [3:0] target;
    input       strobe;
    begin
      hit = strobe && (a == target);
    end
  endfunction

  assign op       = wdata[7:0];
  assign cmd_wr   = hit(addr, `DSQ_A_CMD, wr);
  assign data_wr  = hit(addr, `DSQ_A_DATA, wr);
  assign data_rd  = hit(addr, `DSQ_A_DATA, rd);
  assign stat_rd  = hit(addr, `DSQ_A_CMD, rd);
  assign fail_lba = lba_q + {19'h0_0000, sdone_q};
  // prefetch keeps the next word ready so a data read still answers in one cycle
  assign raddr    = (st_q == S_RBUF && data_rd) ? ptr_q + 8'h01 : ptr_q;
  assign mem_we    = (st_q == S_WBUF) && data_wr;
  // every register access, not only commands, restarts the power-down count
  assign host_acc  = wr || rd;
  assign ptr_last  = (ptr_q == `DSQ_WORDS_LAST);
  assign sect_last = (wcnt_q == `DSQ_WORDS_LAST);
  // service is legal only for the released command once it has become ready
  assign svc_ok    = (op == `DSQ_OP_SVC) && (st_q == S_QREL) && srv_q;
  // DF and COR are never raised; bit 4 doubles as spindle-ready outside queued commands
  assign status    = {bsy_q, !bsy_q, 1'b0, qact_q ? srv_q : spin_at_speed, drq_q, 1'b0, 1'b0, errb_q};

  dsq_buf_mem u_mem (
    .mclk    (mclk),
    .we      (mem_we),
    .waddr   (ptr_q),
    .wdata   (wdata),
    .raddr   (raddr),
    .rdata_q (mem_rdata)
  );

  dsq_pd_timer #(
    .TICK_CYC (PD_TICK_CYC)
  ) u_pd (
    .mclk     (mclk),
    .rst      (rst),
    .timeout  (pdcfg_q),
    .restart  (host_acc),
    .expire_q (pd_expire)
  );

  // task-file writes from the host; the device owns them while busy
  always @(posedge mclk) begin
    if (rst) begin
      feat_q  <= 8'h00;
      snum_q  <= 8'h00;
      cyll_q  <= 8'h00;
      cylh_q  <= 8'h00;
      devh_q  <= 8'h00;
      pdcfg_q <= 8'h00;
    end else begin
      if (wr && !bsy_q) begin
        case (addr)
          `DSQ_A_FEAT:  feat_q  <= wdata[7:0];
          `DSQ_A_SNUM:  snum_q  <= wdata[7:0];
          `DSQ_A_CYLL:  cyll_q  <= wdata[7:0];
          `DSQ_A_CYLH:  cylh_q  <= wdata[7:0];
          `DSQ_A_DEVH:  devh_q  <= wdata[7:0];
          `DSQ_A_PDCFG: pdcfg_q <= wdata[7:0];
          default: ;
        endcase
      end
      if (st_q == S_QEND && spin_at_speed && qerr_q) begin
        snum_q <= fail_lba[7:0];
        cyll_q <= fail_lba[15:8];
        cylh_q <= fail_lba[23:16];
        devh_q <= {devh_q[7:4], fail_lba[27:24]};
      end
    end
  end

  // command sequencer
  always @(posedge mclk) begin
    if (rst) begin
      st_q           <= S_IDLE;
      scnt_q         <= 8'h00;
      err_q          <= 8'h00;
      bsy_q          <= 1'b0;
      drq_q          <= 1'b0;
      errb_q         <= 1'b0;
      srv_q          <= 1'b0;
      qact_q         <= 1'b0;
      qerr_q         <= 1'b0;
      tag_q          <= 5'h00;
      nsec_q         <= 9'h000;
      sdone_q        <= 9'h000;
      lba_q          <= 28'h000_0000;
      wcnt_q         <= 8'h00;
      ptr_q          <= 8'h00;
      intrq_q        <= 1'b0;
      dmarq_q        <= 1'b0;
      media_wvalid_q <= 1'b0;
      media_wdata_q  <= 16'h0000;
      spin_en_q      <= 1'b0;
    end else begin
      media_wvalid_q <= 1'b0;
      // a new completion in the same cycle as a status read keeps the interrupt
      if (stat_rd) begin
        intrq_q <= 1'b0;
      end
      if (hit(addr, `DSQ_A_SCNT, wr) && !bsy_q) begin
        scnt_q <= wdata[7:0];
      end
      case (st_q)
        S_IDLE, S_QREL: begin
          if (st_q == S_QREL && media_ready) begin
            srv_q <= 1'b1;
          end
          if (pd_expire && st_q == S_IDLE) begin
            spin_en_q <= 1'b0;
          end
          if (cmd_wr) begin
            err_q  <= 8'h00;
            errb_q <= 1'b0;
            case (op)
              `DSQ_OP_STBI0, `DSQ_OP_STBI1: begin
                // timer settings untouched; an already stopped spindle skips the spin-down
                if (spin_en_q) begin
                  spin_en_q <= 1'b0;
                end
                intrq_q   <= 1'b1;
              end
              `DSQ_OP_WBUF: begin
                st_q  <= S_WBUF;
                drq_q <= 1'b1;
                ptr_q <= 8'h00;
              end
              `DSQ_OP_RBUF: begin
                st_q  <= S_RBUF;
                drq_q <= 1'b1;
                ptr_q <= 8'h00;
              end
              `DSQ_OP_WDQ0, `DSQ_OP_WDQ1: begin
                tag_q     <= scnt_q[7:3];
                nsec_q    <= (feat_q == 8'h00) ? `DSQ_NSEC_ZERO : {1'b0, feat_q};
                lba_q     <= {devh_q[3:0], cylh_q, cyll_q, snum_q};
                sdone_q   <= 9'h000;
                wcnt_q    <= 8'h00;
                qerr_q    <= 1'b0;
                qact_q    <= 1'b1;
                spin_en_q <= 1'b1;
                if (media_ready) begin
                  st_q    <= S_QXFR;
                  bsy_q   <= 1'b1;
                  dmarq_q <= 1'b1;
                end else begin
                  st_q   <= S_QREL;
                  scnt_q <= {scnt_q[7:3], `DSQ_SC_REL};
                  srv_q  <= 1'b0;
                end
              end
              default: begin
                if (svc_ok) begin
                  st_q    <= S_QXFR;
                  bsy_q   <= 1'b1;
                  dmarq_q <= 1'b1;
                end else begin
                  err_q[`DSQ_ER_ABT] <= 1'b1;
                  errb_q             <= 1'b1;
                  intrq_q            <= 1'b1;
                end
              end
            endcase
          end
        end
        S_WBUF: begin
          if (data_wr) begin
            ptr_q <= ptr_q + 8'h01;
            if (ptr_last) begin
              st_q    <= S_IDLE;
              drq_q   <= 1'b0;
              intrq_q <= 1'b1;
            end
          end
        end
        S_RBUF: begin
          if (data_rd) begin
            ptr_q <= ptr_q + 8'h01;
            if (ptr_last) begin
              st_q    <= S_IDLE;
              drq_q   <= 1'b0;
              intrq_q <= 1'b1;
            end
          end
        end
        S_QXFR: begin
          // no release path exists from here until every sector has moved
          if (media_err) begin
            st_q    <= S_QEND;
            dmarq_q <= 1'b0;
            qerr_q  <= 1'b1;
          end else if (dma_strobe) begin
            media_wvalid_q <= 1'b1;
            media_wdata_q  <= dma_data;
            wcnt_q         <= wcnt_q + 8'h01;
            if (sect_last) begin
              sdone_q <= sdone_q + 9'h001;
              if (sdone_q + 9'h001 == nsec_q) begin
                st_q    <= S_QEND;
                dmarq_q <= 1'b0;
              end
            end
          end
        end
        S_QEND: begin
          if (spin_at_speed) begin
            st_q   <= S_IDLE;
            scnt_q <= {tag_q, `DSQ_SC_DONE};
            srv_q  <= 1'b0;
            qact_q <= 1'b0;
            bsy_q  <= 1'b0;
            intrq_q <= 1'b1;
            if (qerr_q) begin
              err_q[`DSQ_ER_IDN] <= 1'b1;
              errb_q             <= 1'b1;
            end
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // read data one cycle after the strobe
  always @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `DSQ_A_DATA:  rdata_q <= (st_q == S_RBUF) ? mem_rdata : 16'h0000;
        `DSQ_A_FEAT:  rdata_q <= {8'h00, err_q};
        `DSQ_A_SCNT:  rdata_q <= {8'h00, scnt_q};
        `DSQ_A_SNUM:  rdata_q <= {8'h00, snum_q};
        `DSQ_A_CYLL:  rdata_q <= {8'h00, cyll_q};
        `DSQ_A_CYLH:  rdata_q <= {8'h00, cylh_q};
        `DSQ_A_DEVH:  rdata_q <= {8'h00, devh_q};
        `DSQ_A_CMD:   rdata_q <= {8'h00, status};
        `DSQ_A_PDCFG: rdata_q <= {8'h00, pdcfg_q};
        `DSQ_A_PWR:   rdata_q <= {13'h0000, qact_q, spin_at_speed, spin_en_q};
        default:      rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
endmodule

// ### dsq_cmd_assertions.sv
// port checks for the command block
`timescale 1ns/1ns
module dsq_cmd_chk #(
  parameter PD_TICK_CYC = 10
) (
  input wire        mclk,
  input wire        rst,
  input wire [3:0]  addr,
  input wire [15:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [15:0] rdata_q,
  input wire        intrq_q,
  input wire        dmarq_q,
  input wire        dma_strobe,
  input wire [15:0] dma_data,
  input wire        media_wvalid_q,
  input wire [15:0] media_wdata_q,
  input wire        media_ready,
  input wire        media_err,
  input wire        spin_en_q,
  input wire        spin_at_speed
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire stby = wr && addr == 4'h7 && (wdata[7:0] == 8'hE0 || wdata[7:0] == 8'h94);
  a_stby_spin_down: assert property (
    stby && !dmarq_q && !intrq_q |=> !spin_en_q && intrq_q) else $error("standby not entered");
  a_word_forward: assert property (
    dmarq_q && dma_strobe && !media_err |=> media_wvalid_q && media_wdata_q == $past(dma_data))
    else $error("word lost");
  a_media_cause: assert property (
    media_wvalid_q |-> $past(dma_strobe && dmarq_q)) else $error("media write without dma word");
  a_dma_cmd_cause: assert property (
    $rose(dmarq_q) |-> $past(wr) && $past(addr) == 4'h7) else $error("dma request without command");
  a_dma_spin_on: assert property (
    $rose(dmarq_q) |-> spin_en_q) else $error("data phase with spindle off");
  a_irq_after_data: assert property (
    $rose(intrq_q) |-> !dmarq_q) else $error("interrupt during data phase");
  a_no_early_stop: assert property (
    $fell(dmarq_q) && !$past(rst) |-> $past(dma_strobe) || $past(dma_strobe, 2) || $past(media_err))
    else $error("data phase left early");
  a_rd_idle_zero: assert property (
    !rd |=> rdata_q == 16'h0000) else $error("read data outside read slot");
endmodule
bind dsq_cmd dsq_cmd_chk #(.PD_TICK_CYC(PD_TICK_CYC)) u_chk (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata_q(rdata_q), .intrq_q(intrq_q), .dmarq_q(dmarq_q), .dma_strobe(dma_strobe),
  .dma_data(dma_data), .media_wvalid_q(media_wvalid_q), .media_wdata_q(media_wdata_q),
  .media_ready(media_ready), .media_err(media_err), .spin_en_q(spin_en_q), .spin_at_speed(spin_at_speed));

// ### dsq_media_model.sv
// spindle and media stand-in on the far side of the command block
`timescale 1ns/1ns
module dsq_media_model #(
  parameter SPIN_CYC = 20
) (
  input  wire mclk,
  input  wire rst,
  input  wire spin_en,
  input  wire stall,
  input  wire fail,
  output reg  at_speed_q,
  output reg  ready_q,
  output reg  err_q
);
  reg [7:0] cnt_q;
  // spin-up takes real time, so completion has to wait for it
  always @(posedge mclk) begin
    if (rst || !spin_en) begin
      cnt_q      <= 8'h00;
      at_speed_q <= 1'b0;
    end else if (cnt_q < SPIN_CYC) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      at_speed_q <= 1'b1;
    end
    ready_q <= !rst && !stall;
    err_q   <= !rst && fail;
  end
endmodule

// ### tb_dsq_cmd.sv
// self-checking bench for the command block
`timescale 1ns/1ns
`include "dsq_defs.vh"
module tb_dsq_cmd;
  reg         mclk, rst, wr, rd, dma_strobe, stall, fail;
  reg  [3:0]  addr;
  reg  [15:0] wdata, dma_data, mw;
  reg  [8:0]  n;
  wire [15:0] rdata_q, media_wdata_q;
  wire        intrq_q, dmarq_q, media_wvalid_q, media_ready, media_err, spin_en_q, spin_at_speed;
  integer     n_errors, compares, j, k, nw;
  dsq_cmd #(.PD_TICK_CYC(10)) DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .intrq_q(intrq_q), .dmarq_q(dmarq_q), .dma_strobe(dma_strobe), .dma_data(dma_data),
    .media_wvalid_q(media_wvalid_q), .media_wdata_q(media_wdata_q), .media_ready(media_ready),
    .media_err(media_err), .spin_en_q(spin_en_q), .spin_at_speed(spin_at_speed));
  dsq_media_model u_media (.mclk(mclk), .rst(rst), .spin_en(spin_en_q), .stall(stall), .fail(fail),
    .at_speed_q(spin_at_speed), .ready_q(media_ready), .err_q(media_err));
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
    end
  endtask
  task rc(input [3:0] a, input [15:0] mask, input [15:0] exp);
    begin
      @(posedge mclk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata_q & mask, exp);
    end
  endtask
  task wait_hi(input sel);
    begin
      k = 0;
      while ((sel ? dmarq_q : intrq_q) !== 1'b1 && k < 2000) begin
        @(posedge mclk);
        k = k + 1;
      end
      if (k == 2000) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: wait timed out", $time);
        tally_and_finish;
      end
    end
  endtask
  task dma(input integer cnt);
    begin
      for (j = 0; j < cnt; j = j + 1) begin
        @(posedge mclk);
        dma_strobe <= 1'b1;
        dma_data   <= j[15:0];
      end
      @(posedge mclk);
      dma_strobe <= 1'b0;
    end
  endtask
  task qcmd(input [7:0] feat, input [4:0] tag, input [7:0] op);
    begin
      wr_reg(4'h1, {8'h00, feat});
      wr_reg(4'h2, {8'h00, tag, 3'b000});
      wr_reg(4'h3, 16'h0010);
      wr_reg(4'h4, 16'h0020);
      wr_reg(4'h5, 16'h0030);
      wr_reg(4'h6, 16'h00E1);
      wr_reg(4'h7, {8'h00, op});
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rst) begin
      nw <= 0;
      mw <= 16'h0000;
    end else if (media_wvalid_q === 1'b1) begin
      nw <= nw + 1;
      mw <= media_wdata_q;
    end
  end
  initial begin
    {rst, wr, rd, dma_strobe, stall, fail} = 6'b10_0000;
    {addr, wdata, dma_data} = 36'h0_0000_0000;
    n_errors = 0;
    compares = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rc(4'hF, 16'hFFFF, 16'h0000);
    wr_reg(4'h7, {8'h00, `DSQ_OP_WBUF});
    for (n = 0; n < 256; n = n + 1)
      wr_reg(4'h0, {n[7:0], ~n[7:0]});
    wait_hi(0);
    rc(4'h7, 16'h00A5, 16'h0000);
    wr_reg(4'h7, {8'h00, `DSQ_OP_RBUF});
    for (n = 0; n < 256; n = n + 1)
      rc(4'h0, 16'hFFFF, {n[7:0], ~n[7:0]});
    wait_hi(0);
    rc(4'h7, 16'h00A5, 16'h0000);
    chk({15'h0000, nw == 0}, 16'h0001);
    $display("buffer test done");
    qcmd(8'h00, 5'd5, `DSQ_OP_WDQ0);
    wait_hi(1);
    dma(65536);
    wait_hi(0);
    chk({15'h0000, nw == 65536}, 16'h0001);
    chk(mw, 16'hFFFF);
    chk({14'h0000, dmarq_q, spin_at_speed}, 16'h0001);
    rc(4'h2, 16'h00FF, {8'h00, 5'd5, 3'b011});
    rc(4'h7, 16'h00A5, 16'h0000);
    $display("direct queued test done");
    wr_reg(4'h8, 16'h0003);
    for (n = 0; n < 2; n = n + 1) begin
      wr_reg(4'h7, {8'h00, n[0] ? `DSQ_OP_STBI1 : `DSQ_OP_STBI0});
      #1 chk({14'h0000, spin_en_q, intrq_q}, 16'h0001);
      rc(4'h7, 16'h00A5, 16'h0000);
    end
    rc(4'h8, 16'h00FF, 16'h0003);
    wr_reg(4'h8, 16'h0000);
    $display("standby test done");
    @(posedge mclk);
    stall <= 1'b1;
    qcmd(8'h02, 5'd9, `DSQ_OP_WDQ1);
    rc(4'h2, 16'h00FF, {8'h00, 5'd9, 3'b100});
    rc(4'h7, 16'h0010, 16'h0000);
    stall <= 1'b0;
    repeat (3) @(posedge mclk);
    rc(4'h7, 16'h0010, 16'h0010);
    wr_reg(4'h7, {8'h00, `DSQ_OP_SVC});
    wait_hi(1);
    dma(512);
    wait_hi(0);
    chk({15'h0000, spin_at_speed}, 16'h0001);
    rc(4'h2, 16'h00FF, {8'h00, 5'd9, 3'b011});
    rc(4'h7, 16'h00A5, 16'h0000);
    $display("released queued test done");
    qcmd(8'h02, 5'd3, `DSQ_OP_WDQ0);
    wait_hi(1);
    dma(300);
    fail <= 1'b1;
    wait_hi(0);
    rc(4'h7, 16'h0001, 16'h0001);
    rc(4'h1, 16'h0010, 16'h0010);
    rc(4'h3, 16'h00FF, 16'h0011);
    rc(4'h4, 16'h00FF, 16'h0020);
    rc(4'h5, 16'h00FF, 16'h0030);
    rc(4'h6, 16'h000F, 16'h0001);
    fail <= 1'b0;
    $display("media error test done");
    wr_reg(4'h8, 16'h0002);
    repeat (12) @(posedge mclk);
    rc(4'h8, 16'h00FF, 16'h0002);
    repeat (12) @(posedge mclk);
    chk({15'h0000, spin_en_q}, 16'h0001);
    repeat (24) @(posedge mclk);
    chk({15'h0000, spin_en_q}, 16'h0000);
    $display("power-down test done");
    tally_and_finish;
  end
endmodule
